//--- rtl/pcg_consts.svh
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// ==========================================================================
// Register map (byte addresses on the APB)
`define PCG_ADDR_W        8
`define PCG_NUM_REGS      6
`define PCG_NUM_GATES     37
`define PCG_OFS_ANALOG    8'h00
`define PCG_OFS_COMPARE   8'h04
`define PCG_OFS_CAPCMP    8'h08
`define PCG_OFS_TIMER     8'h0c
`define PCG_OFS_SERIAL    8'h10
`define PCG_OFS_MISC      8'h14
`define PCG_GATE_RESET    1'h0

// ==========================================================================
// Gate placement: register index and bit position, one per module entry
`define PCG_REG_IDX '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, \
  3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, \
  3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, \
  3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5}
`define PCG_BIT_POS '{5'h00, 5'h08, 5'h0c, 5'h00, 5'h01, 5'h02, \
  5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, \
  5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h00, 5'h01, 5'h02, 5'h03, 5'h04, \
  5'h08, 5'h09, 5'h0a, 5'h0b, 5'h10, 5'h11, 5'h18, 5'h1c, 5'h00, 5'h01, 5'h10}
`define PCG_ALL_PRESENT   37'h1f_ffff_ffff

`endif

//--- rtl/pcg_pkg.sv
package pcg_pkg;

  // ========================================================================
  // Module entries, in the order of the gate vector
  typedef enum logic [5:0] {
    converter_gate        = 6'h00,
    charge_time_unit_gate = 6'h01,
    comparator_vref_gate  = 6'h02,
    comparator1_gate      = 6'h03,
    capture1_gate         = 6'h06,
    compare1_gate         = 6'h0b,
    timer1_gate           = 6'h10,
    uart_port1_gate       = 6'h15,
    spi_port1_gate        = 6'h1a,
    i2c_port1_gate        = 6'h1e,
    i2c_port2_gate        = 6'h1f,
    usb_module_gate       = 6'h20,
    can_ctrl_gate         = 6'h21,
    real_time_clock_gate  = 6'h22,
    ref_clock_out_gate    = 6'h23,
    parallel_port_gate    = 6'h24
  } pcg_module_t;

  // ========================================================================
  // Decoded APB access
  typedef struct packed {
    logic       hit;
    logic [2:0] idx;
    logic       wr;
    logic       rd;
  } pcg_access_t;

endpackage : pcg_pkg

//--- rtl/pcg_clock_gate.sv
`timescale 1ns/10ps

// ==========================================================================
// Latch based clock gate: the latched enable only changes while the clock is low
module pcg_clock_gate (
  input  wire logic clk_in,   // Source clock
  input  wire logic enable,   // Run request, changes after rising edges
  output wire logic clk_out   // Gated clock
);

  logic en_latch;

  // Transparent on low phase so the AND never sees a change mid pulse
  always_latch begin
    if (!clk_in) begin
      en_latch <= enable;
    end
  end

  assign clk_out = clk_in & en_latch;

endmodule : pcg_clock_gate

//--- rtl/pcg_ctrl.sv
`timescale 1ns/10ps
`include "pcg_consts.svh"

// What this block does
// - A set gate bit stops the clock of its module.
// - A gated module's registers ignore writes; its reads are undefined.
// - Writing one gates a module, zero enables it; reset clears all.
// - Analog register: converter bit 0, charge-time unit 8, vref 12.
// - Comparator register: comparators one to three at bits 0 to 2.
// - Capture/compare register: capture one to five at bits 0 to 4.
// - Capture/compare register: compare one to five at bits 16 to 20.
// - Timer register: timers one to five at bits 0 to 4.
// - Serial register: UART ports one to five at bits 0 to 4.
// - Serial register: SPI ports one to four at bits 8 to 11.
// - Serial register: I2C ports one and two at bits 16, 17.
// - Serial register: USB at bit 24, CAN at bit 28.
// - Misc register: clock calendar 0, reference out 1, parallel port 16.
// - Gate bits exist only for modules present on this variant.
module pcg_ctrl #(
  parameter logic [`PCG_NUM_GATES-1:0] PRESENT = `PCG_ALL_PRESENT  // Modules built
) (
  input  wire logic                      clock,          // Peripheral bus clock
  input  wire logic                      reset_n,        // Asynchronous reset
  input  wire logic                      psel,           // APB select
  input  wire logic                      penable,        // APB access phase
  input  wire logic                      pwrite,         // APB direction
  input  wire logic [`PCG_ADDR_W-1:0]    paddr,          // APB byte address
  input  wire logic [31:0]               pwdata,         // APB write data
  output logic      [31:0]               prdata,         // APB read data
  output wire logic                      pready,         // APB ready
  output wire logic                      pslverr,        // APB error
  output logic      [`PCG_NUM_GATES-1:0] module_gate_bit, // Gate state per module
  output wire logic [`PCG_NUM_GATES-1:0] module_clk,     // Gated module clocks
  input  wire logic [`PCG_NUM_GATES-1:0] periph_sel_in,  // Module register selects
  output wire logic [`PCG_NUM_GATES-1:0] periph_sel_out  // Selects passed to modules
);

  // Gate placement map and register offsets
  localparam logic [2:0] REG_IDX [`PCG_NUM_GATES] = `PCG_REG_IDX;
  localparam logic [4:0] BIT_POS [`PCG_NUM_GATES] = `PCG_BIT_POS;
  localparam logic [`PCG_ADDR_W-1:0] REG_OFS [`PCG_NUM_REGS] = '{`PCG_OFS_ANALOG,
    `PCG_OFS_COMPARE, `PCG_OFS_CAPCMP, `PCG_OFS_TIMER, `PCG_OFS_SERIAL, `PCG_OFS_MISC};

  logic [1:0]             rst_sync_r;
  logic                   rst_n;
  pcg_pkg::pcg_access_t   acc;
  logic [31:0]            view [`PCG_NUM_REGS];
  logic [31:0]            impl_mask [`PCG_NUM_REGS];
  logic [31:0]            rd_view;
  logic [31:0]            rd_mask;
  logic [31:0]            prdata_nxt;
  logic [`PCG_NUM_REGS-1:0] reg_match;
  logic [`PCG_NUM_REGS-1:0] reg_wr;

  // ========================================================================
  // Reset release through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'h1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ========================================================================
  // APB decode: zero wait states, error on unmapped address
  assign acc.hit = |reg_match;
  assign acc.idx = paddr[4:2];
  assign acc.wr  = psel && penable && pwrite && acc.hit;
  assign acc.rd  = psel && !penable && !pwrite && acc.hit;
  assign pready  = 1'h1;
  assign pslverr = psel && penable && !acc.hit;

  // Address match and write strobe per register, from the offset map
  genvar k;
  generate
    for (k = 0; k < `PCG_NUM_REGS; k++) begin : gen_reg
      assign reg_match[k] = (paddr == REG_OFS[k]);
      assign reg_wr[k]    = acc.wr && reg_match[k];
    end
  endgenerate

  // ========================================================================
  // One gate flop per present module, placed by the map
  genvar g;
  generate
    for (g = 0; g < `PCG_NUM_GATES; g++) begin : gen_gate
      if (PRESENT[g]) begin : gen_on
        logic gate_r;
        logic gate_nxt;

        // Write one gates, zero enables
        assign gate_nxt = reg_wr[REG_IDX[g]] ? pwdata[BIT_POS[g]] : gate_r;

        always_ff @(posedge clock or negedge rst_n) begin
          if (!rst_n) begin
            gate_r <= `PCG_GATE_RESET;
          end else begin
            gate_r <= gate_nxt;
          end
        end

        assign module_gate_bit[g] = gate_r;
      end else begin : gen_off
        assign module_gate_bit[g] = 1'h0;
      end

      // Clock stops glitch free while gated
      pcg_clock_gate u_gate (
        .clk_in  (clock),
        .enable  (!module_gate_bit[g]),
        .clk_out (module_clk[g])
      );

      // Register selects of a gated module are blocked
      assign periph_sel_out[g] = periph_sel_in[g] & !module_gate_bit[g];
    end
  endgenerate

  // ========================================================================
  // Register views: unassigned positions stay zero
  always_comb begin
    for (int r = 0; r < `PCG_NUM_REGS; r++) begin
      view[r]      = 32'h0;
      impl_mask[r] = 32'h0;
    end
    for (int i = 0; i < `PCG_NUM_GATES; i++) begin
      view[REG_IDX[i]][BIT_POS[i]]      = module_gate_bit[i];
      impl_mask[REG_IDX[i]][BIT_POS[i]] = PRESENT[i];
    end
  end

  // Read selection: named layout checks use these
  assign rd_view    = acc.hit ? view[acc.idx] : 32'h0;
  assign rd_mask    = acc.hit ? impl_mask[acc.idx] : 32'h0;
  assign prdata_nxt = acc.rd ? rd_view : prdata;

  // Read data captured in setup, shown in access
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else begin
      prdata <= prdata_nxt;
    end
  end

  // ========================================================================
  // Checks
  sequence s_write(logic [2:0] r);
    psel && penable && pwrite && acc.hit && acc.idx == r;
  endsequence

  sequence s_read_setup;
    psel && !penable && !pwrite && acc.hit;
  endsequence

  sequence s_refused_access;
    psel && penable && !acc.hit;
  endsequence

  a_reset_enabled: assert property (
    @(posedge clock) $rose(rst_n) |-> module_gate_bit == '0)
    else $error("gate not clear after reset");

  a_converter_bit: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h0) |=> module_gate_bit[0] == (PRESENT[0] & $past(pwdata[0])))
    else $error("converter gate wrong");

  a_usb_can_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h4) |=> module_gate_bit[32] == (PRESENT[32] & $past(pwdata[24]))
      && module_gate_bit[33] == (PRESENT[33] & $past(pwdata[28])))
    else $error("usb or can gate wrong");

  a_capture_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h2) |=> module_gate_bit[10:6] == (PRESENT[10:6] & $past(pwdata[4:0])))
    else $error("capture gates wrong");

  a_compare_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h2) |=> module_gate_bit[15:11] == (PRESENT[15:11] & $past(pwdata[20:16])))
    else $error("compare gates wrong");

  a_gates_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(psel && penable && pwrite) |=> $stable(module_gate_bit))
    else $error("gate changed without write");

  a_unused_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_setup ##1 (psel && penable) |-> (prdata & ~$past(rd_mask)) == 32'h0)
    else $error("unassigned bit read nonzero");

  a_read_value: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_setup ##1 (psel && penable) |-> prdata == $past(rd_view))
    else $error("read data mismatch");

  a_gated_blocked: assert property (
    @(posedge clock) disable iff (!rst_n)
    (periph_sel_out & module_gate_bit) == '0)
    else $error("gated module selected");

  a_unmapped_err: assert property (
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && paddr[`PCG_ADDR_W-1:2] > 6'h05) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // A module gated over a whole low phase sees no high phase
  a_clock_stopped: assert property (
    @(negedge clock) disable iff (!rst_n)
    (module_gate_bit & $past(module_gate_bit) & module_clk) == '0)
    else $error("gated clock still running");

  // A module enabled over a whole low phase sees a full high phase
  a_clock_running: assert property (
    @(negedge clock) disable iff (!rst_n)
    (~module_gate_bit & ~$past(module_gate_bit) & ~module_clk) == '0)
    else $error("enabled clock not running");

  // Charge-time unit and vref gates follow their write
  a_charge_time_unit_vref_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h0) |=>
      module_gate_bit[1] == (PRESENT[1] & $past(pwdata[8])) &&
      module_gate_bit[2] == (PRESENT[2] & $past(pwdata[12])))
    else $error("analog gates wrong");

  // Comparator gates follow their write
  a_comparator_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h1) |=>
      module_gate_bit[5:3] == (PRESENT[5:3] & $past(pwdata[2:0])))
    else $error("comparator gates wrong");

  // Timer gates follow their write, in timer order
  a_timer_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h3) |=>
      module_gate_bit[20:16] == (PRESENT[20:16] & $past(pwdata[4:0])))
    else $error("timer gates wrong");

  // UART gates follow their write, in port order
  a_uart_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h4) |=>
      module_gate_bit[25:21] == (PRESENT[25:21] & $past(pwdata[4:0])))
    else $error("uart gates wrong");

  // SPI gates follow their write, in port order
  a_spi_order: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h4) |=>
      module_gate_bit[29:26] == (PRESENT[29:26] & $past(pwdata[11:8])))
    else $error("spi gates wrong");

  // I2C gates follow their write
  a_i2c_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h4) |=>
      module_gate_bit[31:30] == (PRESENT[31:30] & $past(pwdata[17:16])))
    else $error("i2c gates wrong");

  // Calendar, reference out and parallel port gates follow their write
  a_misc_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h5) |=>
      module_gate_bit[35:34] == (PRESENT[35:34] & $past(pwdata[1:0])) &&
      module_gate_bit[36] == (PRESENT[36] & $past(pwdata[16])))
    else $error("misc gates wrong");

  // A write to the analog register leaves every other gate alone
  a_analog_only: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h0) |=>
      $stable(module_gate_bit[36:3]))
    else $error("analog write hit other gates");

  // A write to the misc register leaves every other gate alone
  a_misc_only: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_write(3'h5) |=>
      $stable(module_gate_bit[33:0]))
    else $error("misc write hit other gates");

  // A refused access changes no gate
  a_refused_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_refused_access |=>
      $stable(module_gate_bit))
    else $error("refused access changed a gate");

  // Misaligned addresses are flagged
  a_misaligned_err: assert property (
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && paddr[1:0] != 2'h0) |->
      pslverr)
    else $error("misaligned access not flagged");

  // Mapped aligned addresses answer without error
  a_mapped_ok: assert property (
    @(posedge clock) disable iff (!rst_n)
    (psel && penable && paddr[1:0] == 2'h0 && paddr[`PCG_ADDR_W-1:2] < 6'h06) |->
      !pslverr)
    else $error("mapped access flagged");

  // Read data only moves on a mapped read setup
  a_read_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(psel && !penable && !pwrite && acc.hit) |=>
      $stable(prdata))
    else $error("read data moved without read");

  // Read data is clear as reset releases
  a_reset_prdata: assert property (
    @(posedge clock)
    $rose(rst_n) |->
      prdata == 32'h0)
    else $error("read data not clear after reset");

endmodule : pcg_ctrl

//--- testbench/pcg_periph_model.sv
`timescale 1ns/10ps

// ==========================================================================
// Peripheral modules: flag clock edges seen and short high phases
module pcg_periph_model (
  input  wire logic [36:0] module_clk, // Clocks into the modules
  input  wire logic        clr,        // Clears the edge flags
  output logic      [36:0] ticked,     // Rising edge seen since clear
  output logic      [36:0] glitch      // High phase shorter than normal
);
  for (genvar i = 0; i < 37; i++) begin : g_mod
    realtime t_up = 0;
    // Record clock activity; a gated module sees none
    always @(posedge module_clk[i] or posedge clr) begin
      if (clr) ticked[i] <= 1'b0;
      else begin
        ticked[i] <= 1'b1;
        t_up = $realtime;
      end
    end
    // A partial pulse shows as a short high phase
    always @(negedge module_clk[i]) begin
      if ($realtime - t_up < 4.5) glitch[i] <= 1'b1;
    end
    initial glitch[i] = 1'b0;
  end
endmodule : pcg_periph_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps

// ==========================================================================
// Gate controller bench: APB accesses with expected values
module tb_top;
  localparam logic [36:0] PRES = 37'h0f_ffff_ffff; // Parallel port not built
  localparam logic [36:0] ALL  = 37'h1f_ffff_ffff;
  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [36:0] sel_in  = 37'h0;
  logic        clr     = 1'b0;
  logic [31:0] prdata, q, q0;
  logic        pready, pslverr, err;
  logic [36:0] gate, mclk, sel_out, ticked, glitch;
  int          bad_count = 0;
  int          n_checks  = 0;
  logic [31:0] mask [6] = '{32'h1101, 32'h7, 32'h1f_001f, 32'h1f, 32'h1103_0f1f, 32'h3};
  logic [36:0] span [6] = '{37'h7, 37'h38, 37'hffc0, 37'h1f_0000, 37'h3_ffe0_0000,
                            37'h0c_0000_0000};

  always #5 clock = ~clock;

  pcg_ctrl #(.PRESENT(PRES)) u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .module_gate_bit(gate), .module_clk(mclk),
    .periph_sel_in(sel_in), .periph_sel_out(sel_out));
  pcg_periph_model u_periph (.module_clk(mclk), .clr(clr), .ticked(ticked), .glitch(glitch));

  task automatic chk(input string nm, input logic [36:0] seen, input logic [36:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // One APB transfer; holds the request until pready is seen high, for at most 16 cycles
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask : apb

  // Clear the edge flags, then let module clocks run a few cycles
  task automatic pulse_clr;
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 0;
    repeat (4) @(posedge clock);
    #1;
  endtask : pulse_clr

  // Gate a single module and check where its bit lands
  task automatic one(input logic [7:0] a, input logic [31:0] d, input logic [36:0] exp);
    apb(1'b1, a, d);
    #1;
    chk("single gate", gate, exp);
    apb(1'b1, a, 32'h0);
  endtask : one

  // Main sequence; modules stay idle, so gating is always legal
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    sel_in  <= ALL;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", q, 37'h0);
    end
    chk("reset gates", gate, 37'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'(i * 4), 32'hffff_ffff);
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("read back", q, mask[i]);
      chk("gate bits", gate, span[i]);
      chk("selects", sel_out, ~span[i]);
      pulse_clr();
      chk("clocks", ticked, ~span[i]);
      apb(1'b1, 8'(i * 4), 32'h0);
    end
    one(8'h08, 32'h0001_0000, 37'h800);
    one(8'h08, 32'h0000_0010, 37'h400);
    one(8'h10, 32'h0100_0000, 37'h1_0000_0000);
    one(8'h00, 32'h0000_1000, 37'h4);
    apb(1'b1, 8'h00, 32'hffff_ffff);
    apb(1'b0, 8'h00, 32'h0);
    q0 = q;
    apb(1'b1, 8'h18, 32'h0);
    chk("unmapped error", 37'(err), 37'h1);
    apb(1'b1, 8'h02, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("refused read", q, q0);
    chk("refused write", gate, span[0]);
    apb(1'b1, 8'h00, 32'h0);
    pulse_clr();
    chk("clocks back", ticked, ALL);
    chk("no glitch", glitch, 37'h0);
    @(posedge clock);
    sel_in <= 37'h0;
    @(posedge clock);
    #1;
    chk("selects off", sel_out, 37'h0);
    finish_test();
  end

  // Whole-run limit
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
endmodule : tb_top
